// ### src/scd_pkg.sv
/*
  Shared constants and types for the strap configuration decoder.
  Assumes the resistor-sensing front end reports each multi-level strap as a level code.
*/
package scd_pkg;

  // ==========================================================
  // Resistor level codes reported by the sensing front end
  // ==========================================================
  typedef enum logic [2:0] {
    SCD_LVL_200K_DOWN,
    SCD_LVL_200K_UP,
    SCD_LVL_10K_DOWN,
    SCD_LVL_10K_UP,
    SCD_LVL_10R_DOWN,
    SCD_LVL_10R_UP
  } scd_level_t;

  // Pull sensed on a shared serial pin.
  typedef enum logic [1:0] {
    SCD_PULL_NONE,
    SCD_PULL_UP,
    SCD_PULL_DOWN
  } scd_pull_t;

  // Function of the shared serial pins.
  typedef enum logic [2:0] {
    SCD_SIF_ROM,
    SCD_SIF_MGMT,
    SCD_SIF_BRIDGE,
    SCD_SIF_UART,
    SCD_SIF_PROBE
  } scd_sif_t;

  // Programmable pin function mode (configuration 1 to 6).
  typedef enum logic [2:0] {
    SCD_FN_MIXED,
    SCD_FN_ROLE_SWAP,
    SCD_FN_SPEED_IND,
    SCD_FN_GPIO_RSVD,
    SCD_FN_CHARGE_IND,
    SCD_FN_FULL_UART
  } scd_func_t;

  // ==========================================================
  // Sizes and ROM signature location
  // ==========================================================
  localparam int SCD_PORTS = 4;
  localparam logic [15:0] SCD_SIG_ADDR = 16'hFFFA;
  localparam logic [SCD_PORTS-1:0] SCD_NO_PORTS = 4'h0;
  localparam logic [SCD_PORTS-1:0] SCD_PORT_1 = 4'h1;
  localparam logic [SCD_PORTS-1:0] SCD_PORT_12 = 4'h3;
  localparam logic [SCD_PORTS-1:0] SCD_PORT_123 = 4'h7;
  localparam logic [SCD_PORTS-1:0] SCD_PORT_1234 = 4'hF;

endpackage

// ### src/scd_port_map.sv
/*
  Translates one multi-level strap code into a mask of ports 1 to 4.
  Purely combinational; the caller registers the result.
*/
`timescale 1ns/10ps
module scd_port_map
  import scd_pkg::*;
(
  input scd_pkg::scd_level_t level,
  output logic [scd_pkg::SCD_PORTS-1:0] mask
);

  // ==========================================================
  // Level to port mask
  // ==========================================================
  // port count decode.
  // Up-tied 10 ohm is undefined for these straps and is treated as all ports.
  always_comb begin
    unique case (level)
      SCD_LVL_200K_DOWN: mask = SCD_NO_PORTS;
      SCD_LVL_200K_UP: mask = SCD_PORT_1;
      SCD_LVL_10K_DOWN: mask = SCD_PORT_12;
      SCD_LVL_10K_UP: mask = SCD_PORT_123;
      SCD_LVL_10R_DOWN: mask = SCD_PORT_1234;
      default: mask = SCD_PORT_1234;
    endcase
  end

endmodule

// ### src/scd_strap_decoder.sv
/*
  Strap configuration decoder: latches every strap at reset release and
  derives the serial pin mode, port disables, fixed and charging port masks
  and the programmable pin function mode.
  Assumes straps are stable around reset release and that the ROM probe
  reports its result once as a level pair (rom_check_done, rom_sig_ok).
*/
// Overview of operation
// - Capture all straps at reset release and hold them until the next reset.
// - Pull-ups on data-out and clock pins select management slave mode.
// - Pull-down on data-out, clock unpulled, selects UART mode.
// - No pulls on either pin: start in serial ROM master mode.
// - No valid ROM found: fall back to I2C bridging mode.
// - ROM valid only with upgrade signature at the fixed byte address.
// - Never run UART with slave or ROM, nor slave with bridging.
// - Management slave usable only in configurations 1, 2, 3 or 6.
// - Configurations 4 and 5 leave the management slave unavailable.
// - Bridging needs bridging strap, configuration 1,2,3,6 and register setup.
// - Each port has positive and negative line disable straps, high disables.
// - Port disabled only when both of its line straps are high.
// - Disabling a port's USB 2.0 side also disables its USB 3 side.
// - Fixed port strap five levels map to zero through four fixed ports.
// - Charging strap five levels map to zero through four charging ports.
// - Function strap six levels map to configurations one through six.
`timescale 1ns/10ps
module scd_strap_decoder
  import scd_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input scd_pkg::scd_pull_t rom_data_out_pull,
  input scd_pkg::scd_pull_t rom_clock_pull,
  input scd_pkg::scd_level_t fixed_port_strap,
  input scd_pkg::scd_level_t charging_port_strap,
  input scd_pkg::scd_level_t programmable_function_pins,
  input wire logic [scd_pkg::SCD_PORTS-1:0] port_pos_line_disable,
  input wire logic [scd_pkg::SCD_PORTS-1:0] port_neg_line_disable,
  input wire logic rom_check_done,
  input wire logic rom_sig_ok,
  input wire logic bridge_regs_ready,
  output logic [15:0] rom_sig_addr,
  output logic straps_valid,
  output scd_pkg::scd_sif_t serial_if_mode_strap,
  output scd_pkg::scd_func_t func_mode,
  output logic mgmt_slave_en,
  output logic bridge_en,
  output logic uart_en,
  output logic rom_master_en,
  output logic func_cfg_reserved,
  output logic [scd_pkg::SCD_PORTS-1:0] usb2_port_disable,
  output logic [scd_pkg::SCD_PORTS-1:0] usb3_port_disable,
  output logic [scd_pkg::SCD_PORTS-1:0] fixed_port_mask,
  output logic [scd_pkg::SCD_PORTS-1:0] charging_port_mask,
  output logic shared_pins_are_straps
);

  // ==========================================================
  // Capture stage
  // ==========================================================
  logic cap_done_q;
  scd_pull_t do_pull_q;
  scd_pull_t clk_pull_q;
  scd_level_t fn_lvl_q;
  logic [SCD_PORTS-1:0] dis_p_q;
  logic [SCD_PORTS-1:0] dis_m_q;
  logic [SCD_PORTS-1:0] fixed_q;
  logic [SCD_PORTS-1:0] charge_q;
  logic [SCD_PORTS-1:0] fixed_d;
  logic [SCD_PORTS-1:0] charge_d;
  scd_sif_t sif_q;
  scd_sif_t sif_d;
  logic probe_done_q;

  scd_port_map u_fixed_map (
    .level(fixed_port_strap),
    .mask(fixed_d)
  );

  scd_port_map u_charge_map (
    .level(charging_port_strap),
    .mask(charge_d)
  );

  // strap latch.
  // Reset loads constants only; the pins are caught on the first edge after release.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cap_done_q <= 1'b0;
      do_pull_q <= SCD_PULL_NONE;
      clk_pull_q <= SCD_PULL_NONE;
      fn_lvl_q <= SCD_LVL_200K_DOWN;
      dis_p_q <= SCD_NO_PORTS;
      dis_m_q <= SCD_NO_PORTS;
      fixed_q <= SCD_NO_PORTS;
      charge_q <= SCD_NO_PORTS;
    end else if (!cap_done_q) begin
      cap_done_q <= 1'b1;
      do_pull_q <= rom_data_out_pull;
      clk_pull_q <= rom_clock_pull;
      fn_lvl_q <= programmable_function_pins;
      dis_p_q <= port_pos_line_disable;
      dis_m_q <= port_neg_line_disable;
      fixed_q <= fixed_d;
      charge_q <= charge_d;
    end
  end

  // ==========================================================
  // Serial pin mode selection
  // ==========================================================
  wire pulls_mgmt = (do_pull_q == SCD_PULL_UP) && (clk_pull_q == SCD_PULL_UP);
  wire pulls_uart = (do_pull_q == SCD_PULL_DOWN) && (clk_pull_q == SCD_PULL_NONE);
  wire pulls_none = (do_pull_q == SCD_PULL_NONE) && (clk_pull_q == SCD_PULL_NONE);

  // mode choice.
  // Any other pull pattern is undefined; it is routed to the ROM path, the safest default.
  always_comb begin
    sif_d = sif_q;
    if (cap_done_q && sif_q == SCD_SIF_PROBE) begin
      if (pulls_mgmt) begin
        sif_d = SCD_SIF_MGMT;
      end else if (pulls_uart) begin
        sif_d = SCD_SIF_UART;
      end else begin
        // Unpulled pins, and any undefined pattern, start on the ROM path.
        sif_d = SCD_SIF_ROM;
      end
    end else if (sif_q == SCD_SIF_ROM && rom_check_done && !probe_done_q) begin
      sif_d = rom_sig_ok ? SCD_SIF_ROM : SCD_SIF_BRIDGE;
    end
  end

  // Mode register and a one-shot marker so the ROM verdict is taken only once.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sif_q <= SCD_SIF_PROBE;
      probe_done_q <= 1'b0;
    end else begin
      sif_q <= sif_d;
      if (sif_q == SCD_SIF_ROM && rom_check_done) begin
        probe_done_q <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Function mode and interface enables
  // ==========================================================
  // function mode decode.
  scd_func_t fn_mode;
  always_comb begin
    unique case (fn_lvl_q)
      SCD_LVL_200K_DOWN: fn_mode = SCD_FN_MIXED;
      SCD_LVL_200K_UP: fn_mode = SCD_FN_ROLE_SWAP;
      SCD_LVL_10K_DOWN: fn_mode = SCD_FN_SPEED_IND;
      SCD_LVL_10K_UP: fn_mode = SCD_FN_GPIO_RSVD;
      SCD_LVL_10R_DOWN: fn_mode = SCD_FN_CHARGE_IND;
      SCD_LVL_10R_UP: fn_mode = SCD_FN_FULL_UART;
      default: fn_mode = SCD_FN_FULL_UART;
    endcase
  end

  // bus pins routed only in 1, 2, 3 and 6.
  wire fn_has_bus = (fn_mode != SCD_FN_GPIO_RSVD) && (fn_mode != SCD_FN_CHARGE_IND);
  // Staying in ROM mode after the verdict already means the signature was found,
  // so the live ok line is not read again and cannot disturb the settled outputs.
  wire rom_known = probe_done_q;

  // exclusive enables follow the single mode register.
  // bridging gated by function mode and register setup.
  assign mgmt_slave_en = (sif_q == SCD_SIF_MGMT) && fn_has_bus;
  assign bridge_en = (sif_q == SCD_SIF_BRIDGE) && fn_has_bus && bridge_regs_ready;
  assign uart_en = (sif_q == SCD_SIF_UART);
  assign rom_master_en = (sif_q == SCD_SIF_ROM);
  // shared pins act as straps outside ROM mode and the probe state.
  assign shared_pins_are_straps = (sif_q != SCD_SIF_ROM) && (sif_q != SCD_SIF_PROBE);
  assign func_cfg_reserved = (fn_mode == SCD_FN_GPIO_RSVD);
  assign func_mode = fn_mode;
  assign serial_if_mode_strap = sif_q;
  assign rom_sig_addr = SCD_SIG_ADDR;
  assign straps_valid = cap_done_q && (sif_q != SCD_SIF_PROBE) && (sif_q != SCD_SIF_ROM || rom_known);

  // ==========================================================
  // Port disables
  // ==========================================================
  // per-port both-lines check.
  // USB 3 side follows USB 2 side.
  genvar gi;
  generate
    for (gi = 0; gi < SCD_PORTS; gi++) begin : g_port
      assign usb2_port_disable[gi] = dis_p_q[gi] & dis_m_q[gi];
      assign usb3_port_disable[gi] = dis_p_q[gi] & dis_m_q[gi];
    end
  endgenerate

  assign fixed_port_mask = fixed_q;
  assign charging_port_mask = charge_q;

  // ==========================================================
  // Checks
  // ==========================================================
  held_straps_a: assert property (@(posedge clk) disable iff (!rst_n)
    cap_done_q |=> $stable(fixed_port_mask) && $stable(usb2_port_disable) && $stable(func_mode))
    else $error("Captured straps changed after capture.");

  mgmt_pick_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(cap_done_q) && pulls_mgmt |=> sif_q == SCD_SIF_MGMT)
    else $error("Pull-ups did not select management slave.");

  uart_pick_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(cap_done_q) && pulls_uart |=> sif_q == SCD_SIF_UART)
    else $error("Pull-down did not select UART.");

  rom_first_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(cap_done_q) && pulls_none |=> sif_q == SCD_SIF_ROM)
    else $error("Unpulled pins did not start in ROM mode.");

  rom_fallback_a: assert property (@(posedge clk) disable iff (!rst_n)
    sif_q == SCD_SIF_ROM && rom_check_done && !probe_done_q && !rom_sig_ok |=> sif_q == SCD_SIF_BRIDGE)
    else $error("Missing ROM did not fall back to bridging.");

  excl_modes_a: assert property (@(posedge clk) disable iff (!rst_n)
    !(uart_en && (mgmt_slave_en || rom_master_en)) && !(mgmt_slave_en && bridge_en))
    else $error("Exclusive serial interfaces enabled together.");

  mgmt_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
    (func_mode == SCD_FN_GPIO_RSVD || func_mode == SCD_FN_CHARGE_IND) |-> !mgmt_slave_en && !bridge_en)
    else $error("Bus interface enabled in configuration 4 or 5.");

  port_dis_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(cap_done_q) |-> usb2_port_disable == $past(port_pos_line_disable & port_neg_line_disable))
    else $error("Port disable does not need both lines high.");

  usb3_follow_a: assert property (@(posedge clk) disable iff (!rst_n)
    usb3_port_disable == usb2_port_disable)
    else $error("USB 3 side not disabled with USB 2 side.");

endmodule

// ### testbench/scd_rom_model.sv
/*
  Partner model of the serial configuration ROM seen through the probe.
  Assumes the bench sets rom_present and rom_delay while reset is held.
*/
`timescale 1ns/10ps
module scd_rom_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic rom_master_en,
  input wire logic rom_present,
  input wire logic [3:0] rom_delay,
  output logic rom_check_done,
  output logic rom_sig_ok
);
  logic [3:0] wait_q;

  // ==========================================================
  // Probe answer
  // ==========================================================
  // One verdict per reset, held until the next reset; before it the ok line
  // toggles every cycle so a stale level can never pass as a verdict.
  // signature at address
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_q <= 4'h0;
      rom_check_done <= 1'b0;
      rom_sig_ok <= 1'b0;
    end else if (!rom_check_done) begin
      if (rom_master_en && wait_q == rom_delay) begin
        rom_check_done <= 1'b1;
        rom_sig_ok <= rom_present;
      end else begin
        wait_q <= rom_master_en ? wait_q + 4'h1 : wait_q;
        rom_sig_ok <= ~rom_sig_ok;
      end
    end
  end
endmodule

// ### testbench/tb_scd_strap_decoder.sv
/*
  Self-checking bench for the strap decoder, with a reference model in tasks.
  Assumes scd_pkg is compiled first and the ROM partner model is present.
*/
`timescale 1ns/10ps
module tb_scd_strap_decoder;
  import scd_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  scd_pull_t dpull = SCD_PULL_NONE, cpull = SCD_PULL_NONE;
  scd_level_t fx = SCD_LVL_200K_DOWN, ch = SCD_LVL_200K_DOWN, fn = SCD_LVL_200K_DOWN;
  logic [3:0] pos = 4'h0, neg = 4'h0, dly = 4'h0, d2, d3, fmask, cmask, cp4, cn4;
  logic present = 1'b0, rdy = 1'b0, done, ok, svalid, mgmt, brg, uart, romm, rsvd, pstr;
  logic [15:0] sig_addr;
  scd_sif_t mode, em;
  scd_func_t func;
  int n_mismatch = 0, n_checks = 0, cx, cc, cf;

  // ==========================================================
  // Design, partner and clock
  // ==========================================================
  scd_strap_decoder i_scd_strap_decoder (.clk(clk), .rst_n(rst_n), .rom_data_out_pull(dpull),
    .rom_clock_pull(cpull), .fixed_port_strap(fx), .charging_port_strap(ch),
    .programmable_function_pins(fn), .port_pos_line_disable(pos), .port_neg_line_disable(neg),
    .rom_check_done(done), .rom_sig_ok(ok), .bridge_regs_ready(rdy), .rom_sig_addr(sig_addr),
    .straps_valid(svalid), .serial_if_mode_strap(mode), .func_mode(func), .mgmt_slave_en(mgmt),
    .bridge_en(brg), .uart_en(uart), .rom_master_en(romm), .func_cfg_reserved(rsvd),
    .usb2_port_disable(d2), .usb3_port_disable(d3), .fixed_port_mask(fmask),
    .charging_port_mask(cmask), .shared_pins_are_straps(pstr));
  scd_rom_model i_scd_rom_model (.clk(clk), .rst_n(rst_n), .rom_master_en(romm),
    .rom_present(present), .rom_delay(dly), .rom_check_done(done), .rom_sig_ok(ok));

  // Free-running 10 MHz clock.
  always #50 clk = ~clk;

  // ==========================================================
  // Comparison, reference model and closing
  // ==========================================================
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask

  // Level code to port mask; the unused 10 ohm pull-up reads as all ports.
  function automatic logic [3:0] pmask(input int l);
    case (l)
      0: return 4'h0;
      1: return 4'h1;
      2: return 4'h3;
      3: return 4'h7;
      default: return 4'hF;
    endcase
  endfunction

  task automatic end_of_test();
    $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Every output except straps_valid against the values captured at reset release.
  task automatic check_all();
    logic sok;
    sok = cf != 3 && cf != 4;
    check(16'(mode), 16'(em));
    check(16'(func), 16'(cf));
    check(16'(rsvd), 16'(cf == 3));
    check(16'(fmask), 16'(pmask(cx)));
    check(16'(cmask), 16'(pmask(cc)));
    check(16'(d2), 16'(cp4 & cn4));
    check(16'(d3), 16'(cp4 & cn4));
    check(16'(mgmt), 16'(em == SCD_SIF_MGMT && sok));
    check(16'(brg), 16'(em == SCD_SIF_BRIDGE && sok && rdy));
    check(16'(uart), 16'(em == SCD_SIF_UART));
    check(16'(romm), 16'(em == SCD_SIF_ROM));
    check(16'(mgmt + uart + romm + brg <= 1), 16'h0001);
    check(16'(pstr), 16'(em != SCD_SIF_ROM));
    check(sig_addr, 16'hFFFA);
  endtask

  // ==========================================================
  // Main sequence: every pull pair, random straps, mid-run resets
  // ==========================================================
  initial begin
    int i, k, dp, cq;
    void'($urandom(21320));
    repeat (4) @(posedge clk);
    for (i = 0; i < 48; i++) begin
      dp = i % 4;
      cq = (i / 4) % 4;
      cx = $urandom_range(5, 0);
      cc = $urandom_range(5, 0);
      cf = $urandom_range(5, 0);
      cp4 = 4'($urandom);
      cn4 = 4'($urandom) | cp4 & 4'($urandom);
      rst_n <= 1'b0;
      dpull <= scd_pull_t'(dp[1:0]);
      cpull <= scd_pull_t'(cq[1:0]);
      fx <= scd_level_t'(cx[2:0]);
      ch <= scd_level_t'(cc[2:0]);
      fn <= scd_level_t'(cf[2:0]);
      pos <= cp4;
      neg <= cn4;
      present <= 1'($urandom);
      rdy <= 1'($urandom);
      dly <= 4'($urandom_range(8, 0));
      @(posedge clk);
      #1;
      check(16'(mode), 16'(SCD_SIF_PROBE));
      check(16'({svalid, fmask, d2}), 16'h0000);
      if (dp == 1 && cq == 1)
        em = SCD_SIF_MGMT;
      else if (dp == 2 && cq == 0)
        em = SCD_SIF_UART;
      else
        em = present ? SCD_SIF_ROM : SCD_SIF_BRIDGE;
      @(posedge clk);
      rst_n <= 1'b1;
      for (k = 0; k < 40 && svalid !== 1'b1; k++) begin
        @(posedge clk);
        #1;
      end
      if (k == 40) begin
        n_mismatch++;
        end_of_test();
      end
      check_all();
      // Straps moved after capture must leave every output except straps_valid alone.
      @(posedge clk);
      fx <= scd_level_t'(3'($urandom_range(5, 0)));
      fn <= scd_level_t'(3'($urandom_range(5, 0)));
      pos <= ~cp4;
      dpull <= scd_pull_t'(2'($urandom_range(2, 0)));
      repeat (3) @(posedge clk);
      #1;
      check_all();
      $display("test %0d done mode=%0d func=%0d", i, em, cf);
    end
    end_of_test();
  end
endmodule
